/* File: core/pad_pull_pkg.sv */
package pad_pull_pkg;

  localparam logic [7:0]  PORT_C_PULL_OFFSET = 8'hB8;
  localparam logic [7:0]  PORT_D_PULL_OFFSET = 8'hBC;
  localparam int          MASK_LSB           = 16;
  localparam int          FIELD_W            = 2;
  localparam int          PORT_C_PADS        = 8;
  localparam int          PORT_D_PADS        = 2;
  localparam logic [15:0] PORT_C_RESET       = 16'h5AAA;
  localparam logic [15:0] PORT_D_RESET       = 16'h0005;
  localparam logic [15:0] PORT_D_RW_MASK     = 16'h000F;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  typedef enum logic [1:0] {
    PULL_HIGH_Z    = 2'h0,
    PULL_UP_WEAK   = 2'h1,
    PULL_DOWN_WEAK = 2'h2,
    PULL_KEEPER    = 2'h3
  } pull_mode_t;

endpackage

/* File: core/pad_pull_control_bank.sv */
`timescale 1ns/100ps
// Behaviour
// (RULE1) A write changes lower bit n only where bit 16+n of the write data is one.
// (RULE2) A lower bit whose mask bit is zero keeps its old value whatever is written.
// (RULE3) Each two-bit pad field gives 00 high impedance, 01 pull-up, 10 pull-down, 11 keeper.
// (RULE4) The port C register sits at 0xB8 with pad 7 in bits 15:14 down to pad 0 in bits 1:0.
// (RULE5) The port D register sits at 0xBC with pads 1 and 0 in bits 3:0, bits 15:4 read-only.
// (RULE6) Reset gives pull-up on port C pads 7, 6 and port D pads; pull-down on C pads 5 to 0.
module pad_pull_control_bank
  import pad_pull_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output pull_mode_t       port_c_pad_pull [PORT_C_PADS],
  output pull_mode_t       port_d_pad_pull [PORT_D_PADS]
);

  logic        aw_held_q;
  logic [7:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [15:0] port_c_q;
  logic [15:0] port_d_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // Address and data are caught independently; the write fires once both are held.
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  wire        aw_take   = s_axi_awvalid && s_axi_awready;
  wire        w_take    = s_axi_wvalid && s_axi_wready;
  wire        wr_fire   = aw_held_q && w_held_q && !bvalid_q;
  wire        hit_c_wr  = aw_addr_q == PORT_C_PULL_OFFSET; // [RULE4]
  wire        hit_d_wr  = aw_addr_q == PORT_D_PULL_OFFSET; // [RULE5]
  // Mask bits live in the upper lanes; a lane whose strobe is off cannot unmask anything.
  wire [15:0] wmask     = w_data_q[31:16] & {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}}
                          & {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [15:0] port_c_d  = (port_c_q & ~wmask) | (w_data_q[15:0] & wmask); // [RULE1] [RULE2]
  wire [15:0] port_d_d  = (port_d_q & ~(wmask & PORT_D_RW_MASK))
                          | (w_data_q[15:0] & wmask & PORT_D_RW_MASK); // [RULE1] [RULE2] [RULE5]
  // An unmapped read returns zero data together with an error response.
  wire        ar_take   = s_axi_arvalid && s_axi_arready;
  wire        hit_c_rd  = s_axi_araddr == PORT_C_PULL_OFFSET;
  wire        hit_d_rd  = s_axi_araddr == PORT_D_PULL_OFFSET;
  wire [31:0] rd_word   = hit_c_rd ? {16'h0000, port_c_q} :
                          hit_d_rd ? {16'h0000, port_d_q} : 32'h0000_0000;

  // The held flags let address and data arrive in either order. Both channels are refused
  // while a response waits, so a second write can never overtake the first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Only a mapped write touches a register; an unmapped one is answered with an error
  // and leaves every pad as it was.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_c_q <= PORT_C_RESET; // [RULE6]
      port_d_q <= PORT_D_RESET; // [RULE6]
    end else if (wr_fire) begin
      if (hit_c_wr) begin
        port_c_q <= port_c_d;
      end
      if (hit_d_wr) begin
        port_d_q <= port_d_d;
      end
    end
  end

  // A new write cannot fire while the response still stands, so the set and the clear of
  // the response flag never meet in one cycle and no response is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (hit_c_wr || hit_d_wr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data are captured at the take edge, so a write landing in that same cycle is seen
  // only by the next read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word; // [RULE6]
      rresp_q  <= (hit_c_rd || hit_d_rd) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // The pad cells see the register bits directly, so a pull change reaches the pins one
  // cycle after the write fires.
  for (genvar p = 0; p < PORT_C_PADS; p++) begin : g_port_c
    assign port_c_pad_pull[p] = pull_mode_t'(port_c_q[FIELD_W*p +: FIELD_W]); // [RULE3] [RULE4]
  end
  for (genvar p = 0; p < PORT_D_PADS; p++) begin : g_port_d
    assign port_d_pad_pull[p] = pull_mode_t'(port_d_q[FIELD_W*p +: FIELD_W]); // [RULE3] [RULE5]
  end

  // Register checks; all but the reset check are idle while reset is applied.
  masked_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
    wr_fire && hit_c_wr |=> port_c_q == $past(port_c_d))
    else $error("port C value differs from masked write");
  unmasked_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    wr_fire && hit_c_wr |=> ((port_c_q ^ $past(port_c_q)) & ~$past(wmask)) == 16'h0000)
    else $error("unmasked port C bit changed");
  pad_decode_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
    port_c_pad_pull[7] == pull_mode_t'(port_c_q[15:14]))
    else $error("pad 7 pull code mismatched");
  port_c_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    ar_take && hit_c_rd |=> rdata_q == {16'h0000, $past(port_c_q)} && rvalid_q)
    else $error("port C read data wrong");
  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
    port_d_q[15:4] == 12'h000)
    else $error("port D reserved bits not zero");
  port_d_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
    !(wr_fire && hit_d_wr) |=> port_d_q == $past(port_d_q))
    else $error("port D changed without write");
  reset_value_a: assert property (@(posedge aclk) // [RULE6]
    !aresetn |=> port_c_q == PORT_C_RESET && port_d_q == PORT_D_RESET)
    else $error("reset value wrong");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
    wr_fire |=> bvalid_q)
    else $error("write response missing");
  // The response is checked one cycle at a time while it waits, so a slow master needs
  // no bound here.
  write_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
    bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped before taken");
  port_d_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
    wr_fire && hit_d_wr |=> port_d_q == $past(port_d_d))
    else $error("port D value differs from masked write");
  port_d_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    wr_fire && hit_d_wr |=> ((port_d_q ^ $past(port_d_q)) & ~$past(wmask)) == 16'h0000)
    else $error("unmasked port D bit changed");
  port_c_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    !(wr_fire && hit_c_wr) |=> port_c_q == $past(port_c_q))
    else $error("port C changed without write");
  port_d_decode_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
    port_d_pad_pull[1] == pull_mode_t'(port_d_q[3:2]))
    else $error("port D pad 1 pull code mismatched");
  write_okay_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    wr_fire && (hit_c_wr || hit_d_wr) |=> bresp_q == RESP_OKAY)
    else $error("mapped write not answered okay");
  write_miss_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    wr_fire && !hit_c_wr && !hit_d_wr |=> bresp_q == RESP_SLVERR
    && port_c_q == $past(port_c_q) && port_d_q == $past(port_d_q))
    else $error("unmapped write not refused");
  read_miss_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    ar_take && !hit_c_rd && !hit_d_rd |=> rresp_q == RESP_SLVERR && rdata_q == 32'h0000_0000)
    else $error("unmapped read not refused");
  read_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    rvalid_q && !s_axi_rready |=> rvalid_q && $stable(rdata_q) && $stable(rresp_q))
    else $error("read data dropped before taken");
  port_d_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
    ar_take && hit_d_rd |=> rdata_q == {16'h0000, $past(port_d_q)} && rvalid_q)
    else $error("port D read data wrong");

  // Covers for the main scenarios.
  c_write_cov: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && hit_c_wr);
  d_write_cov: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && hit_d_wr);
  miss_cov: cover property (@(posedge aclk) disable iff (!aresetn) ar_take && !hit_c_rd && !hit_d_rd);
  keeper_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    port_c_pad_pull[0] == PULL_KEEPER);
  d_read_cov: cover property (@(posedge aclk) disable iff (!aresetn) ar_take && hit_d_rd);

endmodule // pad_pull_control_bank

/* File: dv/pad_pull_control_bank_test.sv */
`timescale 1ns/100ps
module pad_pull_control_bank_test
  import pad_pull_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] mc = 16'h5AAA, md = 16'h0005, m;
  pull_mode_t  pc [PORT_C_PADS];
  pull_mode_t  pd [PORT_D_PADS];
  int          num_errors = 0, cmp_count = 0, n;
  always #5 aclk = ~aclk;
  pad_pull_control_bank dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .port_c_pad_pull(pc), .port_d_pad_pull(pd));
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // The master waits only as long as the loop bound; a stall counts as a mismatch.
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (n == 50) begin num_errors++; end_sim; end
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rsp = rresp; d = rdata;
    rready <= 1'b0;
    if (n == 50) begin num_errors++; end_sim; end
  endtask
  task pads;
    for (int p = 0; p < 8; p++) chk(32'(pc[p]), 32'(mc[2*p+:2]));
    for (int p = 0; p < 2; p++) chk(32'(pd[p]), 32'(md[2*p+:2]));
    rd(8'hB8);
    chk(d, {16'h0000, mc});
    chk(32'(rsp), 32'(RESP_OKAY));
    rd(8'hBC);
    chk(d, {16'h0000, md});
    chk(32'(rsp), 32'(RESP_OKAY));
  endtask
  task wm(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    chk(32'(rsp), 32'(RESP_OKAY));
    m = v[31:16];
    if (a == 8'hB8) mc = (mc & ~m) | (v[15:0] & m);
    else md = (md & ~(m & 16'h000F)) | (v[15:0] & m & 16'h000F);
    pads;
  endtask
  initial begin
    d = $urandom(70);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    pads;
    $display("test reset values done");
    repeat (20) begin
      wm(8'hB8, $urandom);
      wm(8'hBC, $urandom);
    end
    wm(8'hB8, 32'h0000FFFF);
    $display("test masked writes done");
    for (int k = 0; k < 4; k++) begin
      wm(8'hB8, {16'hFFFF, {8{2'(k)}}});
      wm(8'hBC, {16'hFFFF, {8{2'(k)}}});
    end
    $display("test pull codes done");
    // A lane whose strobe is off, mask lane or data lane, must not unmask anything, so nothing may change.
    for (int s = 0; s < 2; s++) begin
      wstrb <= s ? 4'hC : 4'h3;
      wr(8'hB8, 32'hFFFF0000 | $urandom);
      chk(32'(rsp), 32'(RESP_OKAY));
      pads;
    end
    wstrb <= 4'hF;
    $display("test write strobes done");
    wr(8'hC0, 32'hFFFF0000);
    chk(32'(rsp), 32'(RESP_SLVERR));
    rd(8'hC0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    pads;
    $display("test unmapped address done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    mc = 16'h5AAA;
    md = 16'h0005;
    pads;
    $display("test reset in mid-run done");
    end_sim;
  end
endmodule // pad_pull_control_bank_test
